// file: src/mmc_top.sv
// Operating mode sequencer and speed command front end
module mmc_top
	import mmc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Pins
	input wire logic wakePin,
	input wire logic enablePin,
	input wire logic pwmInPin,
	// Supply comparators and OTP flag, already on clk; speed feedback goes through a synchroniser
	input wire logic supplyBelow5v,
	input wire logic supplyAbove28v,
	input wire logic extRegBelow4v2,
	input wire logic extRegBelow2v7,
	input wire logic lowSideSupplyBelow4v8,
	input wire logic otpLoaded,
	input wire logic speedFeedbackOutput,
	// Configuration
	input wire logic overvoltageConfigEnable,
	input wire logic extRegulatorVoltageSelect,
	input wire logic pwmInputFrequencyMode,
	input wire logic speedLoopControlBit,
	input wire logic commandSourceSelect,
	input wire logic [DUTY_W-1:0] directDutyCommand,
	input wire logic [1:0] statusSelectField,
	input wire logic [DUTY_W-1:0] dutyMin,
	input wire logic [DUTY_W-1:0] dutyMax,
	input wire logic [DUTY_W-1:0] targetSpeedMax,
	input wire logic [7:0] pGainRegister,
	input wire logic [7:0] iGainRegister,
	input wire logic [7:0] tGainRegister,
	// Mode and drive
	output logic [1:0] modeState,
	output logic logicResetActive,
	output logic chargePumpEnable,
	output logic gateHighZ,
	output logic gateEnable,
	output logic gateSupplyDischarge,
	output logic spiWriteAllowed,
	output logic spiReadAllowed,
	output logic pwmOut,
	output logic [DUTY_W-1:0] dutyCommand,
	// Diagnostics
	output logic supplyUnderVoltage,
	output logic supplyOverVoltage,
	output logic extRegUnderVoltage,
	output logic lowSideSupplyUnderVoltage,
	output logic pwmAbsentFlag,
	output logic [DUTY_W-1:0] measuredDuty,
	output logic [PER_W-1:0] statusRegister
);
	logic wakeS, enS, pwmS, fbS;
	mmc_sync uWake (.clk(clk), .rstn(rstn), .pinIn(wakePin), .pinSync(wakeS));
	mmc_sync uEn (.clk(clk), .rstn(rstn), .pinIn(enablePin), .pinSync(enS));
	mmc_sync uPwm (.clk(clk), .rstn(rstn), .pinIn(pwmInPin), .pinSync(pwmS));
	mmc_sync uFb (.clk(clk), .rstn(rstn), .pinIn(speedFeedbackOutput), .pinSync(fbS));

	// Mode sequencer
	mmc_mode_t mode_reg, mode_next;
	always_comb begin
		case (mode_reg)
			MMC_SLEEP: mode_next = !wakeS ? MMC_SLEEP : (enS ? MMC_NORMAL : MMC_STANDBY);
			MMC_STANDBY, MMC_NORMAL: begin
				if (!wakeS)
					mode_next = MMC_SLEEP;
				else if (enS)
					mode_next = MMC_NORMAL;
				else
					mode_next = MMC_STANDBY;
			end
			default: mode_next = MMC_SLEEP;
		endcase
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			mode_reg <= MMC_SLEEP;
		else
			mode_reg <= mode_next;
	end
	wire logic inSleep = (mode_reg == MMC_SLEEP);
	wire logic inNormal = (mode_reg == MMC_NORMAL);

	// Fault flags; sleep keeps the core in reset
	logic uvNext, ovNext, regUvNext, lsUvNext, supplyFault;
	always_comb begin
		uvNext = !inSleep && supplyBelow5v;
		ovNext = !inSleep && overvoltageConfigEnable && supplyAbove28v;
		regUvNext = !inSleep && (extRegulatorVoltageSelect ? extRegBelow4v2 : extRegBelow2v7);
		lsUvNext = !inSleep && lowSideSupplyBelow4v8;
		supplyFault = uvNext || ovNext;
	end

	// Input PWM measurement
	logic pwmPrev_reg;
	logic [PER_W-1:0] perCnt_reg, perCnt_next, hiCnt_reg, hiCnt_next;
	logic [PER_W-1:0] period_reg, period_next;
	logic [DUTY_W-1:0] duty_reg, duty_next;
	logic valid_reg, valid_next, newDuty_reg, newDuty_next;
	logic [PER_W-1:0] absentCnt_reg, absentCnt_next;
	logic absent_reg, absent_next;
	logic [PER_W+DUTY_W-1:0] scaled;
	logic [PER_W-1:0] minPeriod;
	logic rise;
	always_comb begin
		rise = pwmS && !pwmPrev_reg;
		minPeriod = pwmInputFrequencyMode ? PER_W'(HI_MIN_PERIOD) : PER_W'(LO_MIN_PERIOD);
		perCnt_next = perCnt_reg;
		hiCnt_next = hiCnt_reg;
		period_next = period_reg;
		duty_next = duty_reg;
		valid_next = valid_reg;
		newDuty_next = 1'b0;
		scaled = '0;
		if (rise) begin
			perCnt_next = PER_W'(1);
			hiCnt_next = PER_W'(1);
			if (valid_reg || (perCnt_reg != '0 && perCnt_reg < PER_W'(NOFREQ_CYCLES))) begin
				if (perCnt_reg >= minPeriod) begin
					period_next = perCnt_reg;
					scaled = (PER_W+DUTY_W)'(hiCnt_reg) * (PER_W+DUTY_W)'(DUTY_FULL);
					duty_next = DUTY_W'(scaled / (PER_W+DUTY_W)'(perCnt_reg));
					valid_next = 1'b1;
					newDuty_next = 1'b1;
				end
			end
		end else if (perCnt_reg >= PER_W'(NOFREQ_CYCLES)) begin
			// Static level: no frequency
			valid_next = 1'b0;
			duty_next = pwmS ? DUTY_FULL : '0;
			newDuty_next = (duty_reg != duty_next);
		end else begin
			perCnt_next = perCnt_reg + 1'b1;
			hiCnt_next = hiCnt_reg + PER_W'(pwmS);
		end
		absentCnt_next = valid_reg ? '0 :
			(absentCnt_reg == PER_W'(ABSENT_CYCLES) ? absentCnt_reg : absentCnt_reg + 1'b1);
		absent_next = !valid_reg && absentCnt_reg == PER_W'(ABSENT_CYCLES);
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pwmPrev_reg <= 1'b0;
			perCnt_reg <= '0;
			hiCnt_reg <= '0;
			period_reg <= '0;
			duty_reg <= '0;
			valid_reg <= 1'b0;
			newDuty_reg <= 1'b0;
			absentCnt_reg <= '0;
			absent_reg <= 1'b0;
		end else if (inSleep) begin
			pwmPrev_reg <= 1'b0;
			perCnt_reg <= '0;
			hiCnt_reg <= '0;
			period_reg <= '0;
			duty_reg <= '0;
			valid_reg <= 1'b0;
			newDuty_reg <= 1'b0;
			absentCnt_reg <= '0;
			absent_reg <= 1'b0;
		end else begin
			pwmPrev_reg <= pwmS;
			perCnt_reg <= perCnt_next;
			hiCnt_reg <= hiCnt_next;
			period_reg <= period_next;
			duty_reg <= duty_next;
			valid_reg <= valid_next;
			newDuty_reg <= newDuty_next;
			absentCnt_reg <= absentCnt_next;
			absent_reg <= absent_next;
		end
	end

	// Speed feedback period, in clock cycles between rising edges
	logic fbPrev_reg;
	logic [PER_W-1:0] fbCnt_reg, fbCnt_next, fbPer_reg, fbPer_next;
	always_comb begin
		fbCnt_next = (fbS && !fbPrev_reg) ? PER_W'(1) :
			(&fbCnt_reg ? fbCnt_reg : fbCnt_reg + 1'b1);
		fbPer_next = (fbS && !fbPrev_reg) ? fbCnt_reg : fbPer_reg;
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fbPrev_reg <= 1'b0;
			fbCnt_reg <= '0;
			fbPer_reg <= '0;
		end else begin
			fbPrev_reg <= fbS;
			fbCnt_reg <= fbCnt_next;
			fbPer_reg <= fbPer_next;
		end
	end

	// Duty translation
	logic [DUTY_W-1:0] translated, span;
	logic [2*DUTY_W-1:0] num;
	logic belowMin;
	always_comb begin
		span = dutyMax - dutyMin;
		num = '0;
		belowMin = (duty_reg <= dutyMin);
		if (belowMin)
			translated = '0;
		else if (duty_reg >= dutyMax)
			translated = DUTY_FULL;
		else begin
			num = (2*DUTY_W)'(duty_reg - dutyMin) * (2*DUTY_W)'(DUTY_FULL);
			translated = DUTY_W'(num / (2*DUTY_W)'(span));
		end
	end

	// PI speed loop, updated once per carrier period
	logic carStart;
	logic signed [23:0] integ_reg, integ_next, err, piSum;
	logic [DUTY_W-1:0] piDuty_reg, piDuty_next;
	logic [PER_W-1:0] speedMeas;
	always_comb begin
		// Speed as a 10-bit figure: faster feedback, shorter period
		speedMeas = (fbPer_reg == '0) ? '0 : PER_W'(PER_W'(1) << 20) / fbPer_reg;
		err = 24'(signed'({1'b0, translated})) * 24'(signed'({1'b0, targetSpeedMax}))
			/ 24'sd1023 - 24'(signed'({1'b0, speedMeas[DUTY_W-1:0]}));
		integ_next = integ_reg;
		piDuty_next = piDuty_reg;
		piSum = '0;
		if (carStart) begin
			integ_next = integ_reg + ((err * 24'(signed'({1'b0, iGainRegister}))) >>> 8);
			piSum = ((err * 24'(signed'({1'b0, pGainRegister}))) >>> 4) +
				(integ_reg >>> tGainRegister[4:0]);
			if (piSum < 0)
				piDuty_next = '0;
			else if (piSum > 24'sd1023)
				piDuty_next = DUTY_FULL;
			else
				piDuty_next = DUTY_W'(piSum);
			if (integ_next > 24'sh3fffff)
				integ_next = 24'sh3fffff;
			else if (integ_next < -24'sh3fffff)
				integ_next = -24'sh3fffff;
		end
		if (!inNormal || belowMin) begin
			integ_next = '0;
			piDuty_next = '0;
		end
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			integ_reg <= '0;
			piDuty_reg <= '0;
		end else begin
			integ_reg <= integ_next;
			piDuty_reg <= piDuty_next;
		end
	end

	// Command select and outputs
	logic [DUTY_W-1:0] cmd, applied_reg, applied_next;
	logic driveOk;
	always_comb begin
		if (commandSourceSelect)
			cmd = directDutyCommand;
		else if (!speedLoopControlBit)
			cmd = piDuty_reg;
		else
			cmd = translated;
		// Applied one cycle after each new measurement; the carrier latches it up to 512 cycles later, past the latency bound
		applied_next = (newDuty_reg || commandSourceSelect || !speedLoopControlBit) ?
			cmd : applied_reg;
		driveOk = inNormal && !supplyFault && !lsUvNext;
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			applied_reg <= '0;
		else
			applied_reg <= inNormal ? applied_next : '0;
	end
	logic carPwm;
	mmc_carrier uCar (.clk(clk), .rstn(rstn), .duty(applied_reg), .pwmOut(carPwm),
		.periodStart(carStart));

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			modeState <= 2'h0;
			logicResetActive <= 1'b1;
			chargePumpEnable <= 1'b0;
			gateHighZ <= 1'b1;
			gateEnable <= 1'b0;
			gateSupplyDischarge <= 1'b0;
			spiWriteAllowed <= 1'b0;
			spiReadAllowed <= 1'b0;
			pwmOut <= 1'b0;
			dutyCommand <= '0;
			supplyUnderVoltage <= 1'b0;
			supplyOverVoltage <= 1'b0;
			extRegUnderVoltage <= 1'b0;
			lowSideSupplyUnderVoltage <= 1'b0;
			pwmAbsentFlag <= 1'b0;
			measuredDuty <= '0;
			statusRegister <= '0;
		end else begin
			modeState <= mode_reg;
			logicResetActive <= inSleep;
			chargePumpEnable <= !inSleep && !ovNext;
			gateHighZ <= inSleep;
			gateEnable <= driveOk;
			gateSupplyDischarge <= ovNext;
			spiWriteAllowed <= (mode_reg == MMC_STANDBY) && otpLoaded;
			spiReadAllowed <= !inSleep;
			pwmOut <= carPwm && driveOk;
			dutyCommand <= applied_reg;
			// Motor-off command also clears the error registers
			supplyUnderVoltage <= uvNext && !belowMin;
			supplyOverVoltage <= ovNext && !belowMin;
			extRegUnderVoltage <= regUvNext && !belowMin;
			lowSideSupplyUnderVoltage <= lsUvNext && !belowMin;
			pwmAbsentFlag <= absent_reg;
			measuredDuty <= duty_reg;
			if (statusSelectField == STAT_SPEED)
				statusRegister <= fbPer_reg;
			else
				statusRegister <= PER_W'(duty_reg);
		end
	end
endmodule

// file: src/mmc_pkg.sv
// Package of constants and types for the motor mode and speed command block
//
// Function
// - Wake low gives sleep; wake high enable low standby; both high normal.
// - Sleep holds logic reset, pump off, drivers high impedance, serial port silent.
// - Standby has loaded stored config, drives gates low, accepts unlocked writes.
// - Normal allows motor drive, all blocks run, all registers readable.
// - Enable low disables motor stage and returns to standby.
// - Supply under 5 V raises under-voltage error; logic keeps running.
// - With protection enabled, supply above 28 V raises over-voltage error.
// - Under or over-voltage drives all six gates low; resume when normal.
// - External regulator under-voltage at 4.2 V (5 V) or 2.7 V (3.3 V).
// - Low-side supply under 4.8 V turns outputs off and sets diagnostic flag.
// - Supply above 28 V disables drivers, flags, discharges both gate supplies; the code does so only with overvoltageConfigEnable set.
// - Accept input to 18.5 kHz in high mode, else ignore above 1 kHz.
// - Input below 5.3 Hz has no frequency; duty follows static level.
// - Input duty measured with 10-bit resolution.
// - Measured duty applied within one input period plus 19.8 us; code latches it at carrier period start, up to 512 cycles later.
// - No valid input after 210 ms sets the absence warning flag.
// - Output carrier fixed at 19.5 kHz in translation and closed-loop modes.
// - Below minimum duty is motor off and clears errors; above maximum full.
// - Output 0 below min, full above max, linear scale between.
// - Speed-loop bit cleared runs PI controller instead of translation.
// - Command-source bit set takes duty from host-written direct register.
// - Status select zero presents measured speed-feedback frequency in status; the code presents the feedback period in clock cycles.
// - Closed loop compares target with measured speed using P, I, T gains.
package mmc_pkg;
	localparam int CLK_HZ = 10000000;
	localparam int DUTY_W = 10;
	localparam logic [DUTY_W-1:0] DUTY_FULL = 10'h3ff;
	// Input frequency limits
	localparam int HI_MAX_HZ = 18500;
	localparam int LO_MAX_HZ = 1000;
	localparam int NOFREQ_MHZ = 5300;
	localparam int HI_MIN_PERIOD = (CLK_HZ + HI_MAX_HZ - 1) / HI_MAX_HZ;
	localparam int LO_MIN_PERIOD = (CLK_HZ + LO_MAX_HZ - 1) / LO_MAX_HZ;
	localparam int NOFREQ_CYCLES = int'((64'(CLK_HZ) * 1000) / NOFREQ_MHZ);
	localparam int PER_W = 22;
	// Absence timeout
	localparam int ABSENT_MS = 210;
	localparam int ABSENT_CYCLES = CLK_HZ / 1000 * ABSENT_MS;
	// Apply latency
	localparam int APPLY_NS = 19800;
	localparam int APPLY_CYCLES = APPLY_NS / 100;
	// Output carrier
	localparam int CARRIER_HZ = 19500;
	localparam int CARRIER_CYCLES = CLK_HZ / CARRIER_HZ;
	localparam int CAR_W = 10;
	// Status select codes
	localparam logic [1:0] STAT_SPEED = 2'h0;
	localparam logic [1:0] STAT_DUTY = 2'h1;
	typedef enum logic [1:0] {
		MMC_SLEEP,
		MMC_STANDBY,
		MMC_NORMAL
	} mmc_mode_t;
endpackage

// file: src/mmc_sync.sv
// Two-flop synchroniser for one pin
module mmc_sync
	import mmc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Pin and result
	input wire logic pinIn,
	output logic pinSync
);
	logic stage1_reg;
	logic stage2_reg;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			stage1_reg <= 1'b0;
			stage2_reg <= 1'b0;
		end else begin
			stage1_reg <= pinIn;
			stage2_reg <= stage1_reg;
		end
	end
	assign pinSync = stage2_reg;
endmodule

// file: src/mmc_carrier.sv
// Fixed-rate output PWM generator
module mmc_carrier
	import mmc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Duty and output
	input wire logic [DUTY_W-1:0] duty,
	output logic pwmOut,
	output logic periodStart
);
	logic [CAR_W-1:0] cnt_reg;
	logic [CAR_W-1:0] cnt_next;
	logic [DUTY_W-1:0] dutyHeld_reg;
	logic [DUTY_W-1:0] dutyHeld_next;
	logic [19:0] thresh;
	always_comb begin
		periodStart = (cnt_reg == CAR_W'(CARRIER_CYCLES - 1));
		cnt_next = periodStart ? '0 : cnt_reg + 1'b1;
		dutyHeld_next = periodStart ? duty : dutyHeld_reg;
		thresh = 20'(dutyHeld_reg) * 20'(CARRIER_CYCLES);
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_reg <= '0;
			dutyHeld_reg <= '0;
			pwmOut <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			dutyHeld_reg <= dutyHeld_next;
			// Full code holds the output high for the whole period
			pwmOut <= (dutyHeld_reg == DUTY_FULL) ||
				(20'(cnt_reg) * 20'(DUTY_FULL) < thresh);
		end
	end
endmodule

// file: testbench/mmc_top_props.sv
// Concurrent checks on the mode and speed command block ports
module mmc_top_props
	import mmc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Inputs watched
	input wire logic wakePin,
	input wire logic enablePin,
	input wire logic supplyBelow5v,
	input wire logic supplyAbove28v,
	input wire logic lowSideSupplyBelow4v8,
	input wire logic commandSourceSelect,
	input wire logic [DUTY_W-1:0] directDutyCommand,
	// Outputs watched
	input wire logic [1:0] modeState,
	input wire logic logicResetActive,
	input wire logic chargePumpEnable,
	input wire logic gateHighZ,
	input wire logic gateEnable,
	input wire logic spiReadAllowed,
	input wire logic pwmOut,
	input wire logic [DUTY_W-1:0] dutyCommand
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	// Pin changes land in four edges, so five samples settle the mode
	// Sampled reset keeps the release edge out of the window
	a_sleep_from_wake: assert property ((rstn && !wakePin)[*5] |-> modeState == 2'h0)
		else $error("mode not sleep with wake low");
	a_standby_from_en: assert property ((rstn && wakePin && !enablePin)[*5]
		|-> modeState == 2'h1)
		else $error("mode not standby with enable low");
	a_normal_from_pins: assert property ((rstn && wakePin && enablePin)[*5]
		|-> modeState == 2'h2)
		else $error("mode not normal with both pins high");
	a_sleep_outputs: assert property (modeState == 2'h0 |->
		gateHighZ && logicResetActive && !chargePumpEnable && !spiReadAllowed)
		else $error("sleep outputs wrong");
	a_standby_gates_low: assert property (modeState == 2'h1 |-> !gateEnable && !gateHighZ)
		else $error("standby gates not low");
	a_normal_enables: assert property ((modeState == 2'h2 && !supplyBelow5v && !supplyAbove28v
		&& !lowSideSupplyBelow4v8)[*3] |-> gateEnable && spiReadAllowed)
		else $error("normal mode not driving");
	a_uv_gates_off: assert property (supplyBelow5v[*3] |-> !gateEnable)
		else $error("gates on during under-voltage");
	a_ov_gates_off: assert property (supplyAbove28v[*3] |-> !gateEnable)
		else $error("gates on during over-voltage");
	a_lowside_off: assert property (lowSideSupplyBelow4v8[*3] |-> !gateEnable)
		else $error("gates on with low-side supply low");
	a_gated_pwm_low: assert property ((!gateEnable)[*3] |-> !pwmOut)
		else $error("output pwm while gates off");
	a_direct_duty: assert property ((commandSourceSelect && modeState == 2'h2
		&& $stable(directDutyCommand))[*4] |-> dutyCommand == directDutyCommand)
		else $error("direct duty not applied");
	c_normal: cover property (modeState == 2'h2 && gateEnable);
	c_uv: cover property (supplyBelow5v && modeState == 2'h2);
	c_direct: cover property (commandSourceSelect && dutyCommand == directDutyCommand);
endmodule

bind mmc_top mmc_top_props uProps (.clk(clk), .rstn(rstn), .wakePin(wakePin),
	.enablePin(enablePin), .supplyBelow5v(supplyBelow5v), .supplyAbove28v(supplyAbove28v),
	.lowSideSupplyBelow4v8(lowSideSupplyBelow4v8), .commandSourceSelect(commandSourceSelect),
	.directDutyCommand(directDutyCommand), .modeState(modeState),
	.logicResetActive(logicResetActive), .chargePumpEnable(chargePumpEnable),
	.gateHighZ(gateHighZ), .gateEnable(gateEnable), .spiReadAllowed(spiReadAllowed),
	.pwmOut(pwmOut), .dutyCommand(dutyCommand));

// file: testbench/mmc_pwm_source.sv
// Model of the external command source: a PWM generator on the system clock
module mmc_pwm_source (
	// Clock
	input wire logic clk,
	// Waveform settings, in clocks
	input wire logic [15:0] highCycles,
	input wire logic [15:0] periodCycles,
	// Line
	output logic pwm
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] cnt = 16'h0;
	// Wraps on a shortened period so settings change cleanly
	always @(posedge clk) begin
		cnt <= (cnt + 16'h1 >= periodCycles) ? 16'h0 : cnt + 16'h1;
		pwm <= (cnt < highCycles);
	end
endmodule

// file: testbench/tb_motor_mode_and_speed_command.sv
// Self-checking bench for the mode and speed command block
module tb_motor_mode_and_speed_command;
	timeunit 1ns;
	timeprecision 1ns;
	import mmc_pkg::*;
	typedef struct {int hi; int per; logic fm; logic [9:0] mn; logic [9:0] mx;
		logic [9:0] md; logic [9:0] dc;} mmc_row_t;
	logic clk, rstn, wakePin, enablePin, pwmInPin, fbPin;
	logic supplyBelow5v, supplyAbove28v, extRegBelow4v2, extRegBelow2v7, lowSideSupplyBelow4v8;
	logic otpLoaded, ovEn, ext_regulator_voltage_select, freqMode, loopBit, srcSel;
	logic [9:0] directDuty, dutyCommand, measuredDuty;
	logic [9:0] dMin, dMax, tgtMax;
	logic [1:0] status_select_field, modeState;
	logic [15:0] hiC, perC;
	logic lra, cpe, ghz, gen, gsd, spiW, spiR, pwmOut, uv, ov, eruv, lsuv, absent;
	logic [PER_W-1:0] statusRegister;
	int failures = 0;
	int n_checks = 0;
	mmc_row_t rows[5] = '{'{100, 1000, 1'b1, 10'h0c8, 10'h320, 10'h066, 10'h000},
		'{500, 1000, 1'b1, 10'h0c8, 10'h320, 10'h1ff, 10'h212},
		'{900, 1000, 1'b1, 10'h0c8, 10'h320, 10'h398, 10'h3ff},
		'{500, 1000, 1'b1, 10'h100, 10'h300, 10'h1ff, 10'h1fd},
		'{6000, 12000, 1'b0, 10'h0c8, 10'h320, 10'h1ff, 10'h212}};
	mmc_pwm_source uSrc (.clk(clk), .highCycles(hiC), .periodCycles(perC), .pwm(pwmInPin));
	mmc_pwm_source uFb (.clk(clk), .highCycles(16'h3e8), .periodCycles(16'h7d0), .pwm(fbPin));
	mmc_top uut (.clk(clk), .rstn(rstn), .wakePin(wakePin), .enablePin(enablePin),
		.pwmInPin(pwmInPin), .supplyBelow5v(supplyBelow5v), .supplyAbove28v(supplyAbove28v),
		.extRegBelow4v2(extRegBelow4v2), .extRegBelow2v7(extRegBelow2v7),
		.lowSideSupplyBelow4v8(lowSideSupplyBelow4v8), .otpLoaded(otpLoaded),
		.speedFeedbackOutput(fbPin), .overvoltageConfigEnable(ovEn),
		.extRegulatorVoltageSelect(ext_regulator_voltage_select), .pwmInputFrequencyMode(freqMode),
		.speedLoopControlBit(loopBit), .commandSourceSelect(srcSel),
		.directDutyCommand(directDuty), .statusSelectField(status_select_field), .dutyMin(dMin),
		.dutyMax(dMax), .targetSpeedMax(tgtMax), .pGainRegister(8'h10),
		.iGainRegister(8'h10), .tGainRegister(8'h04), .modeState(modeState),
		.logicResetActive(lra), .chargePumpEnable(cpe), .gateHighZ(ghz), .gateEnable(gen),
		.gateSupplyDischarge(gsd), .spiWriteAllowed(spiW), .spiReadAllowed(spiR),
		.pwmOut(pwmOut), .dutyCommand(dutyCommand), .supplyUnderVoltage(uv),
		.supplyOverVoltage(ov), .extRegUnderVoltage(eruv), .lowSideSupplyUnderVoltage(lsuv),
		.pwmAbsentFlag(absent), .measuredDuty(measuredDuty), .statusRegister(statusRegister));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic print_verdict();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(string nm, logic [21:0] e, logic [21:0] g);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask
	// Scaling may truncate either way, so one step of slack
	task automatic chk_near(string nm, logic [9:0] e, logic [9:0] g);
		n_checks++;
		if (g !== e && g !== e + 10'h1 && g !== e - 10'h1) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask
	task automatic wait_mode(logic [1:0] e);
		int i;
		for (i = 0; i < 20 && modeState !== e; i++)
			@(posedge clk);
		if (modeState !== e) begin
			failures++;
			$display("unexpected mode wait: expected %h, seen %h", e, modeState);
			print_verdict();
		end
	endtask
	task automatic settle(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Carrier period, counted from one rising edge of the output to the next
	task automatic chk_carrier();
		int n;
		int edges;
		logic prev;
		n = 0;
		edges = 0;
		prev = pwmOut;
		for (int i = 0; i < 2000 && edges < 2; i++) begin
			@(posedge clk);
			#1;
			if (edges == 1)
				n++;
			if (pwmOut && !prev)
				edges++;
			prev = pwmOut;
		end
		chk("carrier period", 22'(CARRIER_CYCLES), 22'(n));
	endtask
	initial begin
		rstn = 1'b0; wakePin = 1'b0; enablePin = 1'b0; supplyBelow5v = 1'b0;
		supplyAbove28v = 1'b0; extRegBelow4v2 = 1'b0; extRegBelow2v7 = 1'b0;
		lowSideSupplyBelow4v8 = 1'b0; otpLoaded = 1'b1; ovEn = 1'b1; ext_regulator_voltage_select = 1'b1;
		freqMode = 1'b1; loopBit = 1'b1; srcSel = 1'b0; directDuty = 10'h0; status_select_field = 2'h0;
		hiC = 16'd500; perC = 16'd1000;
		dMin = 10'h0c8; dMax = 10'h320; tgtMax = 10'h3ff;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		settle(2);
		chk("mode after reset", 22'h0, modeState);
		chk("gate high-z", 22'h1, ghz);
		chk("logic reset", 22'h1, lra);
		chk("pump off in sleep", 22'h0, cpe);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			wakePin <= i[1];
			enablePin <= i[0];
			settle(6);
			chk("mode", !i[1] ? 22'h0 : (i[0] ? 22'h2 : 22'h1), modeState);
			chk("read allowed", 22'(i[1]), spiR);
			chk("gate enable", 22'(i[1] & i[0]), gen);
			chk("write allowed", 22'(i[1] & !i[0]), spiW);
		end
		wait_mode(2'h2);
		foreach (rows[r]) begin
			@(posedge clk);
			hiC <= 16'(rows[r].hi);
			perC <= 16'(rows[r].per);
			freqMode <= rows[r].fm;
			dMin <= rows[r].mn;
			dMax <= rows[r].mx;
			settle(3 * rows[r].per + 200);
			chk("measured duty", 22'(rows[r].md), measuredDuty);
			chk_near("duty command", rows[r].dc, dutyCommand);
		end
		// Too fast for low mode: last valid reading must hold
		@(posedge clk);
		hiC <= 16'd100;
		perC <= 16'd1000;
		settle(5000);
		chk("ignored fast input", 22'h1ff, measuredDuty);
		chk("absent flag", 22'h0, absent);
		@(posedge clk);
		supplyBelow5v <= 1'b1;
		settle(6);
		chk("under-voltage", 22'h1, uv);
		chk("gates in uv", 22'h0, gen);
		@(posedge clk);
		supplyBelow5v <= 1'b0;
		supplyAbove28v <= 1'b1;
		settle(6);
		chk("over-voltage", 22'h1, ov);
		chk("discharge", 22'h1, gsd);
		chk("pump off in ov", 22'h0, cpe);
		@(posedge clk);
		supplyAbove28v <= 1'b0;
		lowSideSupplyBelow4v8 <= 1'b1;
		extRegBelow4v2 <= 1'b1;
		settle(6);
		chk("low-side uv", 22'h1, lsuv);
		chk("ext reg uv 5v", 22'h1, eruv);
		@(posedge clk);
		lowSideSupplyBelow4v8 <= 1'b0;
		ext_regulator_voltage_select <= 1'b0;
		settle(6);
		chk("ext reg uv 3v3", 22'h0, eruv);
		chk("gates resume", 22'h1, gen);
		@(posedge clk);
		srcSel <= 1'b1;
		directDuty <= 10'h155;
		settle(8);
		chk("direct duty", 22'h155, dutyCommand);
		chk("feedback period", 22'h0007d0, statusRegister);
		chk_carrier();
		// Zero target speed makes the loop ask for no drive, unlike translation
		@(posedge clk);
		status_select_field <= 2'h1;
		srcSel <= 1'b0;
		loopBit <= 1'b0;
		tgtMax <= 10'h000;
		settle(1200);
		chk("status duty", 22'h1ff, statusRegister);
		chk("loop duty zero target", 22'h0, dutyCommand);
		@(posedge clk);
		rstn <= 1'b0;
		settle(1);
		chk("mode in reset", 22'h0, modeState);
		chk("high-z in reset", 22'h1, ghz);
		chk("logic reset in reset", 22'h1, lra);
		@(posedge clk);
		rstn <= 1'b1;
		settle(6);
		chk("mode after second reset", 22'h2, modeState);
		print_verdict();
	end
endmodule
